// ---- hw/low_power_mode_control.sv ----
/*
 low-power mode controller: reset-time mode selection, stop/halt/wait states,
 clock gating, interrupt mask bit, watchdog counter and restart delays.
 assumes all inputs synchronous to clk; clk is the free oscillator-derived clock,
 bus and oscillator gating leave this block as enables.
*/
`include "lpm_cfg.svh"

module low_power_mode_control #(
   parameter int WDOG_CYCLES = `LPM_WDOG_CYCLES
) (
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           extResetN,
   input  wire logic           irqHighVolt,
   input  wire logic           capturePin,
   input  wire logic           stopToHalt,
   input  wire logic           wdogOption,
   input  wire logic           stopInstr,
   input  wire logic           waitInstr,
   input  wire logic           iBitSet,
   input  wire logic           iBitClr,
   input  wire logic           irqReq,
   input  wire logic           timerIrq,
   input  wire logic           wdogWrite,
   input  wire logic           wdogWrData,
   output logic                irqToCore,
   output logic                iBit,
   output lpm_pkg::clocks_t    clocks,
   output lpm_pkg::mode_t      mode,
   output lpm_pkg::lpm_state_t lpState,
   output logic                wdogReset
);

   localparam logic [17:0] WdogLast = 18'(WDOG_CYCLES - 1);

   lpm_pkg::ctrl_t ctrl_r;
   lpm_pkg::ctrl_t ctrl_nxt;
   logic           resetRise;
   logic           extWake;
   logic           anyWake;
   logic           wdogActive;
   logic           inRun;

   assign inRun     = ctrl_r.state == lpm_pkg::RUN;
   assign resetRise = extResetN && !ctrl_r.resetPrev;
   // external interrupt passes only with the mask bit clear
   assign extWake   = irqReq && !ctrl_r.iBit;
   assign anyWake   = extWake || (timerIrq && !ctrl_r.iBit);
   assign wdogActive = wdogOption && !irqHighVolt && ctrl_r.mode.singleChip;

   always_comb begin
      ctrl_nxt           = ctrl_r;
      ctrl_nxt.resetPrev = extResetN;
      ctrl_nxt.wdogRst   = 1'b0;

      // interrupt mask bit from the core
      if (iBitSet) begin
         ctrl_nxt.iBit = 1'b1;
      end
      if (iBitClr) begin
         ctrl_nxt.iBit = 1'b0;
      end

      // watchdog counts only while the oscillator runs
      if (ctrl_r.state != lpm_pkg::STOP && ctrl_r.state != lpm_pkg::STAB) begin
         if (wdogActive) begin
            ctrl_nxt.wdogCnt = ctrl_r.wdogCnt + `LPM_WDOG_ONE;
         end
      end
      if (wdogWrite && !wdogWrData && inRun) begin
         ctrl_nxt.wdogCnt = `LPM_WDOG_ZERO;
      end

      // stabilization counter runs free outside stop
      if (ctrl_r.state != lpm_pkg::STOP) begin
         if (ctrl_r.stabCnt == `LPM_STAB_LAST) begin
            ctrl_nxt.stabCnt = `LPM_STAB_ZERO;
         end else begin
            ctrl_nxt.stabCnt = ctrl_r.stabCnt + `LPM_STAB_ONE;
         end
      end

      // only the state and the mask bit change on entry; stop entry also clears stabCnt
      unique case (ctrl_r.state)
         lpm_pkg::RUN: begin
            if (stopInstr) begin
               ctrl_nxt.iBit = 1'b0;
               if (stopToHalt) begin
                  ctrl_nxt.state = lpm_pkg::HALT;
               end else begin
                  ctrl_nxt.state   = lpm_pkg::STOP;
                  ctrl_nxt.stabCnt = `LPM_STAB_ZERO;
               end
            end else if (waitInstr) begin
               ctrl_nxt.iBit  = 1'b0;
               ctrl_nxt.state = lpm_pkg::WAIT;
            end
         end
         lpm_pkg::STOP: begin
            // only the external interrupt or an external reset restarts the oscillator
            if (extWake) begin
               ctrl_nxt.state = lpm_pkg::STAB;
            end
         end
         lpm_pkg::STAB: begin
            if (ctrl_r.stabCnt == `LPM_STAB_LAST) begin
               ctrl_nxt.state = lpm_pkg::RUN;
            end
         end
         lpm_pkg::HALT: begin
            if (anyWake) begin
               ctrl_nxt.state = lpm_pkg::HWAKE;
            end
         end
         lpm_pkg::HWAKE: begin
            // exit waits for the free counter to reach its end
            if (ctrl_r.stabCnt == `LPM_STAB_LAST) begin
               ctrl_nxt.state = lpm_pkg::RUN;
            end
         end
         lpm_pkg::WAIT: begin
            if (anyWake) begin
               ctrl_nxt.state = lpm_pkg::RUN;
            end
         end
         default: begin
            ctrl_nxt.state = lpm_pkg::RUN;
         end
      endcase

      // watchdog timeout: reset, reselect mode from the latched capture level
      if (wdogActive && ctrl_r.wdogCnt == WdogLast &&
          ctrl_r.state != lpm_pkg::STOP && ctrl_r.state != lpm_pkg::STAB) begin
         ctrl_nxt.wdogRst         = 1'b1;
         ctrl_nxt.wdogCnt         = `LPM_WDOG_ZERO;
         ctrl_nxt.state           = lpm_pkg::RUN;
         ctrl_nxt.iBit            = `LPM_IBIT_RESET;
         ctrl_nxt.stabCnt         = `LPM_STAB_ZERO;
         ctrl_nxt.mode.singleChip = !irqHighVolt;
         ctrl_nxt.mode.testMode   = irqHighVolt;
         ctrl_nxt.mode.capLevel   = ctrl_r.capLatch;
      end

      // external reset overrides state, mask bit and both counters, any low-power state is dropped
      if (!extResetN) begin
         ctrl_nxt.state   = lpm_pkg::RUN;
         ctrl_nxt.iBit    = `LPM_IBIT_RESET;
         ctrl_nxt.wdogCnt = `LPM_WDOG_ZERO;
         ctrl_nxt.stabCnt = `LPM_STAB_ZERO;
      end
      if (resetRise) begin
         ctrl_nxt.capLatch        = capturePin;
         ctrl_nxt.mode.singleChip = !irqHighVolt;
         ctrl_nxt.mode.testMode   = irqHighVolt;
         ctrl_nxt.mode.capLevel   = capturePin;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r.state     <= lpm_pkg::RUN;
         ctrl_r.stabCnt   <= `LPM_STAB_ZERO;
         ctrl_r.wdogCnt   <= `LPM_WDOG_ZERO;
         ctrl_r.iBit      <= `LPM_IBIT_RESET;
         ctrl_r.resetPrev <= 1'b0;
         ctrl_r.capLatch  <= 1'b0;
         ctrl_r.mode      <= '0;
         ctrl_r.wdogRst   <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign irqToCore = (irqReq || timerIrq) && !ctrl_r.iBit;
   assign iBit      = ctrl_r.iBit;
   assign mode      = ctrl_r.mode;
   assign lpState   = ctrl_r.state;
   assign wdogReset = ctrl_r.wdogRst;

   always_comb begin
      clocks.busClkEn   = inRun;
      clocks.oscEn      = ctrl_r.state != lpm_pkg::STOP;
      clocks.timerClkEn = ctrl_r.state != lpm_pkg::STOP &&
                          ctrl_r.state != lpm_pkg::STAB;
   end

   // cycles spent in the halt exit, so the exit delay bound needs no long delay range
   logic [11:0] haltWakeCnt_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         haltWakeCnt_r <= `LPM_STAB_ZERO;
      end else if (ctrl_r.state == lpm_pkg::HWAKE) begin
         haltWakeCnt_r <= haltWakeCnt_r + `LPM_STAB_ONE;
      end else begin
         haltWakeCnt_r <= `LPM_STAB_ZERO;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   mode_on_rise_a: assert property (resetRise |=> ctrl_r.capLatch == $past(capturePin)
      && mode.singleChip == !$past(irqHighVolt))
      else $error("mode not taken at reset rise");
   wdog_mode_a: assert property (ctrl_r.wdogRst |-> mode.capLevel == ctrl_r.capLatch)
      else $error("watchdog reset ignored latched capture level");
   single_chip_a: assert property (resetRise && !irqHighVolt |=> mode.singleChip)
      else $error("single-chip mode not entered");
   stop_select_a: assert property (inRun && extResetN && stopInstr && !ctrl_nxt.wdogRst
      |=> lpState == (stopToHalt ? lpm_pkg::HALT : lpm_pkg::STOP))
      else $error("wrong mode after stop instruction");
   osc_off_a: assert property (lpState == lpm_pkg::STOP |-> !clocks.oscEn
      ##1 (!$past(extResetN) || $stable(ctrl_r.wdogCnt)))
      else $error("oscillator or watchdog running in stop");
   mask_clear_a: assert property (inRun && extResetN && (stopInstr || waitInstr)
      && !ctrl_nxt.wdogRst |=> !iBit)
      else $error("mask bit not cleared on sleep entry");
   stop_hold_a: assert property (lpState == lpm_pkg::STOP && !extWake && extResetN
      |=> lpState == lpm_pkg::STOP)
      else $error("stop left without a wake source");
   stop_delay_a: assert property ($rose(lpState == lpm_pkg::STAB) && extResetN
      |-> !clocks.busClkEn [*8] ##0 ctrl_r.stabCnt == 12'h007)
      else $error("bus clock back too early after stop");
   stab_end_a: assert property (lpState == lpm_pkg::STAB ##1 inRun
      |-> $past(ctrl_r.stabCnt) == `LPM_STAB_LAST || !$past(extResetN))
      else $error("stop exit before full delay");
   sleep_clk_a: assert property ((lpState == lpm_pkg::HALT || lpState == lpm_pkg::WAIT)
      |-> !clocks.busClkEn && clocks.timerClkEn)
      else $error("clock gating wrong in halt or wait");
   halt_wake_a: assert property (lpState == lpm_pkg::HALT && anyWake && extResetN
      && !ctrl_nxt.wdogRst |=> lpState == lpm_pkg::HWAKE)
      else $error("halt not left on wake");
   halt_exit_a: assert property (lpState == lpm_pkg::HWAKE
      |-> haltWakeCnt_r <= `LPM_STAB_LAST && !clocks.busClkEn)
      else $error("halt exit delay out of range");
   wait_exit_a: assert property (lpState == lpm_pkg::WAIT && anyWake && extResetN
      && !ctrl_nxt.wdogRst |=> clocks.busClkEn)
      else $error("wait not left on wake");
   mask_gate_a: assert property (iBit |-> !irqToCore)
      else $error("interrupt passed while masked");
   wdog_clear_a: assert property (inRun && extResetN && wdogWrite && !wdogWrData
      |=> ctrl_r.wdogCnt == `LPM_WDOG_ZERO)
      else $error("watchdog not cleared");
   reset_abandon_a: assert property (!extResetN |=> inRun && iBit)
      else $error("reset did not abandon low power");

   stop_cycle_c: cover property (lpState == lpm_pkg::STOP ##1 lpState == lpm_pkg::STAB);
   halt_cycle_c: cover property (lpState == lpm_pkg::HWAKE ##1 inRun);
   wait_cycle_c: cover property (lpState == lpm_pkg::WAIT ##1 inRun);
   wdog_fire_c:  cover property (ctrl_r.wdogRst);

endmodule : low_power_mode_control

// ---- hw/lpm_cfg.svh ----
/*
 constants for the low-power mode controller: cycle counts and reset values.
 assumes a 100 MHz bus clock; included by bare name.
*/
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
`define LPM_STAB_LAST   12'hfdf
`define LPM_STAB_ZERO   12'h000
`define LPM_STAB_ONE    12'h001
`define LPM_WDOG_CYCLES 131072
`define LPM_WDOG_ZERO   18'h00000
`define LPM_WDOG_ONE    18'h00001
`define LPM_IBIT_RESET  1'b1
`endif

// ---- hw/lpm_pkg.sv ----
/*
 types for the low-power mode controller.
 assumes lpm_cfg.svh constants are used with these types.
*/
package lpm_pkg;
   typedef enum logic [2:0] {RUN, STOP, HALT, WAIT, STAB, HWAKE} lpm_state_t;
   typedef struct packed {
      logic singleChip;
      logic testMode;
      logic capLevel;
   } mode_t;
   typedef struct packed {
      logic busClkEn;
      logic oscEn;
      logic timerClkEn;
   } clocks_t;
   typedef struct packed {
      lpm_state_t  state;
      logic [11:0] stabCnt;
      logic [17:0] wdogCnt;
      logic        iBit;
      logic        resetPrev;
      logic        capLatch;
      mode_t       mode;
      logic        wdogRst;
   } ctrl_t;
endpackage : lpm_pkg

// ---- bench/core_model.sv ----
/*
 processor core model: issues stop, wait, mask and watchdog-write pulses.
 assumes the caller steps it from the bench at rising edges of clk.
*/
module core_model (
   input  wire logic clk,
   output logic      stopInstr,
   output logic      waitInstr,
   output logic      iBitSet,
   output logic      iBitClr,
   output logic      wdogWrite,
   output logic      wdogWrData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {stopInstr, waitInstr, iBitSet, iBitClr, wdogWrite, wdogWrData} = 6'h00;
   end
   // one-cycle pulse: 0 stop, 1 wait, 2 mask set, 3 mask clear, 4 clear write, 5 write one
   task automatic issue(input int kind);
      @(posedge clk);
      stopInstr  <= kind == 0;
      waitInstr  <= kind == 1;
      iBitSet    <= kind == 2;
      iBitClr    <= kind == 3;
      wdogWrite  <= kind >= 4;
      wdogWrData <= kind == 5;
      @(posedge clk);
      {stopInstr, waitInstr, iBitSet, iBitClr, wdogWrite, wdogWrData} <= 6'h00;
   endtask : issue
endmodule : core_model

// ---- bench/low_power_mode_control_test.sv ----
/*
 self-checking bench for the low-power mode controller with a core model.
 assumes a 100 MHz clk and a watchdog shortened to 64 cycles.
*/
module low_power_mode_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WDOG = 64;
   logic clk = 0, rst = 1, extResetN = 1, irqHighVolt = 0, capturePin = 0;
   logic stopToHalt = 0, wdogOption = 0, irqReq = 0, timerIrq = 0, cap, hv;
   logic stopInstr, waitInstr, iBitSet, iBitClr, wdogWrite, wdogWrData;
   logic irqToCore, iBit, wdogReset;
   lpm_pkg::clocks_t    clocks;
   lpm_pkg::mode_t      mode;
   lpm_pkg::lpm_state_t lpState;
   int err_count = 0, checks = 0, n;
   always #5 clk = ~clk;
   core_model i_core_model (.clk(clk), .stopInstr(stopInstr), .waitInstr(waitInstr),
      .iBitSet(iBitSet), .iBitClr(iBitClr), .wdogWrite(wdogWrite), .wdogWrData(wdogWrData));
   low_power_mode_control #(.WDOG_CYCLES(WDOG)) i_low_power_mode_control (.clk(clk),
      .rst(rst), .extResetN(extResetN), .irqHighVolt(irqHighVolt), .capturePin(capturePin),
      .stopToHalt(stopToHalt), .wdogOption(wdogOption), .stopInstr(stopInstr),
      .waitInstr(waitInstr), .iBitSet(iBitSet), .iBitClr(iBitClr), .irqReq(irqReq),
      .timerIrq(timerIrq), .wdogWrite(wdogWrite), .wdogWrData(wdogWrData),
      .irqToCore(irqToCore), .iBit(iBit), .clocks(clocks), .mode(mode), .lpState(lpState),
      .wdogReset(wdogReset));
   task automatic tally_and_finish();
      if (err_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : cmp
   // cycles until lpState reaches s, bounded
   task automatic wait_state(input lpm_pkg::lpm_state_t s, input int max);
      n = 0;
      while (lpState !== s) begin
         @(posedge clk);
         #1;
         n++;
         if (n > max) begin
            cmp("state wait", s, lpState);
            tally_and_finish();
         end
      end
   endtask : wait_state
   initial begin
      void'($urandom(32'ha260ad48));
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      #1;
      cmp("state", lpm_pkg::RUN, lpState);
      cmp("clocks", 3'h7, clocks);
      cmp("mode", 3'h4, mode);
      @(posedge clk) irqReq <= 1;
      #1 cmp("masked irq", 0, irqToCore);
      for (int r = 0; r < 4; r++) begin
         cap = $urandom;
         hv = (r < 3) ? 1'($urandom) : 1'b0;
         @(posedge clk);
         {irqReq, extResetN, capturePin, irqHighVolt} <= {1'($urandom), 1'b0, cap, hv};
         @(posedge clk) {irqReq, extResetN} <= 2'h1;
         @(posedge clk);
         #1 cmp("mode", {!hv, hv, cap}, mode);
      end
      i_core_model.issue(1);
      #1 cmp("wait state", lpm_pkg::WAIT, lpState);
      cmp("wait ibit", 0, iBit);
      cmp("wait clocks", 3'h3, clocks);
      cmp("wait mode", {2'h2, cap}, mode);
      i_core_model.issue(0);
      #1 cmp("ignored stop", lpm_pkg::WAIT, lpState);
      @(posedge clk) timerIrq <= 1;
      #1 cmp("open irq", 1, irqToCore);
      @(posedge clk);
      #1 cmp("wait wake", lpm_pkg::RUN, lpState);
      @(posedge clk);
      timerIrq <= 0;
      stopToHalt <= 1;
      i_core_model.issue(0);
      #1 cmp("halt state", lpm_pkg::HALT, lpState);
      cmp("halt clocks", 3'h3, clocks);
      @(posedge clk) timerIrq <= 1;
      wait_state(lpm_pkg::HWAKE, 4);
      wait_state(lpm_pkg::RUN, 4100);
      cmp("halt delay", 1, n >= 1 && n <= 4064);
      @(posedge clk);
      timerIrq <= 0;
      stopToHalt <= 0;
      i_core_model.issue(0);
      #1 cmp("stop state", lpm_pkg::STOP, lpState);
      cmp("stop clocks", 3'h0, clocks);
      @(posedge clk) timerIrq <= 1;
      repeat (6) @(posedge clk);
      #1 cmp("timer no wake", lpm_pkg::STOP, lpState);
      @(posedge clk);
      {timerIrq, irqReq} <= 2'h1;
      wait_state(lpm_pkg::STAB, 4);
      cmp("stab clocks", 3'h2, clocks);
      wait_state(lpm_pkg::RUN, 5000);
      cmp("stop delay", 4064, n);
      @(posedge clk) irqReq <= 0;
      i_core_model.issue(0);
      @(posedge clk) extResetN <= 0;
      @(posedge clk) extResetN <= 1;
      #1 cmp("reset wake", lpm_pkg::RUN, lpState);
      cmp("reset ibit", 1, iBit);
      i_core_model.issue(3);
      #1 cmp("mask clear", 0, iBit);
      i_core_model.issue(2);
      #1 cmp("mask set", 1, iBit);
      @(posedge clk);
      {wdogOption, capturePin} <= {1'b1, !cap};
      i_core_model.issue(4);
      // a write of one must not clear, so the count runs on from the clear
      i_core_model.issue(5);
      #1 n = 0;
      while (wdogReset !== 1'b1 && n <= 200) begin
         @(posedge clk);
         #1 n++;
      end
      cmp("watchdog period", WDOG - 2, n);
      cmp("watchdog mode", {2'h2, cap}, mode);
      cmp("watchdog ibit", 1, iBit);
      i_core_model.issue(0);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         #1 n += wdogReset;
      end
      cmp("stop watchdog", 0, n);
      tally_and_finish();
   end
endmodule : low_power_mode_control_test
